// file: ctrl_regs_consts.svh
// Offsets, field positions and reset values of the host control registers
// How it works
// RULE1: Any write to the burst write leave register ends burst write mode; a burst_write_begin in the cycle the write is taken keeps it set.
// RULE2: Registers ignore accesses while address line zero is high.
// RULE3: Host uses burst transfers only together with the transfer request mechanism.
// RULE4: Loader copy running bit reads 1 from reset until copy completes.
// RULE5: Host polls loader copy status until running bit clears after reset.
// RULE6: Shutdown select 00 all on, 01 lower off, 10 upper off, 11 all off.
// RULE7: Boot window write allow accepts a set only while write ok is 1.
// RULE8: Boot window write ok reads 1 when the window may be written.
// RULE9: Warm reset clears both burst enables unless keep-burst bit is 1.
// RULE10: Warm reset level bit: 0 input active low, 1 active high.
// RULE11: Wake select 0 wakes on chip select; 1 needs full read or write.
// RULE12: Writing 1 to deep sleep request enters deep power down.
// RULE13: Strobe length times core clock gives pulse width; zero suppresses request.
// RULE14: Level style holds request from data ready until early drop point.
// RULE15: Pulse style issues request for strobe length core clocks.
// RULE16: Request enable bit, reset 0, gates the request output.
// RULE17: Request line control register governs request output generation.
// RULE18: Request line level bit, reset 1: 0 active high, 1 active low.
// RULE19: Early drop count, reset 4, sets clocks before end for level release.
// RULE20: Burst enable bit in each burst register enables burst cycles.
`ifndef CTRL_REGS_CONSTS_SVH
`define CTRL_REGS_CONSTS_SVH

// ----------
// Register offsets (host byte address)
// ----------
`define OFS_BURST_WRITE_CTRL 17'h09402
`define OFS_BURST_WRITE_LEAVE 17'h09404
`define OFS_LOADER_COPY_STATUS 17'h09406
`define OFS_BOOT_WINDOW_CONTROL 17'h09408
`define OFS_WARM_RESET_CONFIG 17'h0940A
`define OFS_WAKE_SOURCE_CONFIG 17'h0940C
`define OFS_REQUEST_LINE_CONTROL 17'h0940E
`define OFS_DEEP_SLEEP_ENTRY 17'h09416
`define OFS_EARLY_DROP 17'h09418
`define OFS_BURST_READ_CTRL 17'h09424

// ----------
// Field positions
// ----------
`define BIT_LOADER_RUN 0
`define BIT_WIN_OK 0
`define BIT_WIN_ALLOW 1
`define BIT_SHUT_LO 4
`define BIT_SHUT_HI 5
`define BIT_WARM_LEVEL 0
`define BIT_KEEP_BURST 1
`define BIT_WAKE_SEL 8
`define BIT_SLEEP_REQ 0
`define BIT_REQ_EN 0
`define BIT_REQ_LEVEL 1
`define BIT_REQ_STYLE 2
`define BIT_STROBE_LO 4
`define BIT_STROBE_HI 8
`define BIT_BURST_EN 1
`define BIT_DROP_HI 9

// ----------
// Reset values
// ----------
`define RST_LOADER_RUN 1'b1
`define RST_REQ_LEVEL 1'b1
`define RST_STROBE_LEN 5'h04
`define RST_DROP_COUNT 10'h004
`define WORD_ZERO 16'h0000

`endif

// file: ctrl_regs_pkg.sv
// Shared types of the host control register block
package ctrl_regs_pkg;

  // Request line configuration handed to the strobe generator
  typedef struct packed {
    logic       enable;
    logic       level_low;
    logic       pulse_style;
    logic [4:0] strobe_len;
    logic [9:0] drop_count;
  } req_cfg_s;

  // Host pins after synchronisation
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [16:0] addr;
    logic [15:0] wdata;
    logic        warm_pin;
    logic        sleep_pin;
  } host_pins_s;

  typedef enum logic [1:0] {req_idle, req_level, req_pulse, req_done} req_state_e;

  // Whole state of the register bank
  typedef struct packed {
    logic        loader_run;
    logic        win_allow;
    logic [1:0]  shut_sel;
    logic        keep_burst;
    logic        warm_level;
    logic        wake_sel;
    logic        sleeping;
    logic        burst_rd_en;
    logic        burst_wr_en;
    logic        burst_wr_mode;
    req_cfg_s    req_cfg;
    host_pins_s  prev;
    logic        warm_prev;
    logic        sleep_pin_prev;
    logic        warm_seen;
    logic [15:0] rdata;
    logic        rdata_oe;
  } bank_state_s;

endpackage

// file: pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s state_reg;
  sync_state_s state_next;

  // First stage feeds only the second stage
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      state_next.meta[i]   = pin_in[i];
      state_next.stable[i] = state_reg.meta[i];
    end
  end

  // Idle pins are high (strobes inactive), so reset to ones
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      state_reg <= '1;
    else
      state_reg <= state_next;
  end

  assign pin_out = state_reg.stable;

endmodule

// file: request_strobe.sv
// Transfer request line generator in level or pulse style
`timescale 1ns/1ps
`include "ctrl_regs_consts.svh"
module request_strobe
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire ctrl_regs_pkg::req_cfg_s  cfg,
  input  wire logic                     data_ready,
  input  wire logic [15:0]              clocks_left,
  output logic                          transfer_request_n
);

  typedef struct packed {
    ctrl_regs_pkg::req_state_e st;
    logic [4:0]                count;
    logic                      ready_prev;
    logic                      line;
  } strobe_state_s;

  strobe_state_s state_reg;
  strobe_state_s state_next;
  logic          active;
  logic          start;

  // Request sequencing; zero length suppresses both styles
  always_comb
  begin
    state_next            = state_reg;
    active                = 1'b0;
    start                 = data_ready && !state_reg.ready_prev;
    state_next.ready_prev = data_ready;
    case (state_reg.st)
      ctrl_regs_pkg::req_idle:
      begin
        if (start && cfg.enable && (cfg.strobe_len != 5'h00)) // [RULE13] [RULE16]
        begin
          if (cfg.pulse_style)
          begin
            state_next.st    = ctrl_regs_pkg::req_pulse; // [RULE15]
            state_next.count = cfg.strobe_len;
          end
          else
            state_next.st = ctrl_regs_pkg::req_level; // [RULE14]
        end
      end
      ctrl_regs_pkg::req_level:
      begin
        // Released once remaining clocks reach the early drop point
        if (!data_ready || (clocks_left <= {6'h00, cfg.drop_count})) // [RULE14] [RULE19]
          state_next.st = ctrl_regs_pkg::req_done;
        else
          active = 1'b1;
      end
      ctrl_regs_pkg::req_pulse:
      begin
        active           = 1'b1; // [RULE15]
        state_next.count = state_reg.count - 5'h01;
        if (state_reg.count == 5'h01)
          state_next.st = ctrl_regs_pkg::req_done;
      end
      ctrl_regs_pkg::req_done:
      begin
        // One request per data ready episode
        if (!data_ready)
          state_next.st = ctrl_regs_pkg::req_idle;
      end
      default:
        state_next.st = ctrl_regs_pkg::req_idle;
    endcase
    // Disabling drops any request in flight
    if (!cfg.enable)
    begin
      active        = 1'b0; // [RULE16]
      state_next.st = ctrl_regs_pkg::req_idle;
    end
    state_next.line = active ^ cfg.level_low; // [RULE18] [RULE17]
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg       <= '0;
      state_reg.st    <= ctrl_regs_pkg::req_idle;
      state_reg.line  <= `RST_REQ_LEVEL;
    end
    else
      state_reg <= state_next;
  end

  assign transfer_request_n = state_reg.line;

endmodule

// file: boot_power_dma_control_regs.sv
// Host control registers for boot, power, warm reset and transfer requests
`timescale 1ns/1ps
`include "ctrl_regs_consts.svh"
module boot_power_dma_control_regs
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [15:0] data_in,
  input  wire logic        warm_reset_pin,
  input  wire logic        deep_sleep_pin,
  input  wire logic        loader_copy_done,
  input  wire logic        boot_window_ready,
  input  wire logic        burst_write_begin,
  input  wire logic        xfer_data_ready,
  input  wire logic [15:0] xfer_clocks_left,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             transfer_request_n,
  output logic             boot_window_write_allow,
  output logic             boot_window_write_ok,
  output logic             lower_ram_off,
  output logic             upper_ram_off,
  output logic             burst_read_enable,
  output logic             burst_write_enable,
  output logic             burst_write_active,
  output logic             deep_sleep_active,
  output logic             warm_reset_seen
);

  // ----------
  // Pin synchronisation
  // ----------
  localparam int PIN_W = $bits(ctrl_regs_pkg::host_pins_s);

  ctrl_regs_pkg::host_pins_s pins_raw;
  ctrl_regs_pkg::host_pins_s pins;
  logic [PIN_W-1:0]          pins_sync;

  // Group the asynchronous host pins
  always_comb
  begin
    pins_raw.ce_n      = ce_n;
    pins_raw.oe_n      = oe_n;
    pins_raw.we_n      = we_n;
    pins_raw.addr      = addr;
    pins_raw.wdata     = data_in;
    pins_raw.warm_pin  = warm_reset_pin;
    pins_raw.sleep_pin = deep_sleep_pin;
  end

  pin_sync
  #(
    .WIDTH (PIN_W)
  )
  u_pin_sync
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .pin_in  (pins_raw),
    .pin_out (pins_sync)
  );

  assign pins = ctrl_regs_pkg::host_pins_s'(pins_sync);

  // ----------
  // Register bank state
  // ----------
  ctrl_regs_pkg::bank_state_s state_reg;
  ctrl_regs_pkg::bank_state_s state_next;

  logic        a0_clear;
  logic        wr_event;
  logic        rd_active;
  logic [16:0] wr_addr;
  logic [15:0] wr_data;
  logic        warm_active;
  logic        warm_edge;
  logic        sleep_pin_edge;
  logic        wake_event;
  logic        sleep_enter;
  logic        burst_exit;
  logic [15:0] rd_word;
  logic        rd_hit;

  // Access detection on the synchronised strobes
  always_comb
  begin
    // A0 high leaves these registers deaf, reads and writes alike
    a0_clear  = !state_reg.prev.addr[0]; // [RULE2]
    // Write taken at the trailing edge of write enable, under chip select
    wr_event  = a0_clear && !state_reg.prev.we_n && pins.we_n && !state_reg.prev.ce_n;
    wr_addr   = state_reg.prev.addr;
    wr_data   = state_reg.prev.wdata;
    rd_active = !pins.ce_n && !pins.oe_n && !pins.addr[0]; // [RULE2]
  end

  // Warm reset pin level and wake triggers
  always_comb
  begin
    warm_active    = state_reg.warm_level ? pins.warm_pin : !pins.warm_pin; // [RULE10]
    warm_edge      = warm_active && !state_reg.warm_prev;
    sleep_pin_edge = pins.sleep_pin && !state_reg.sleep_pin_prev;
    // Edges only, so the access that requested sleep cannot wake it
    if (state_reg.wake_sel) // [RULE11]
      wake_event = !pins.ce_n &&
                   ((state_reg.prev.oe_n && !pins.oe_n) ||
                    (state_reg.prev.we_n && !pins.we_n));
    else
      wake_event = state_reg.prev.ce_n && !pins.ce_n; // [RULE11]
    sleep_enter = sleep_pin_edge ||
                  (wr_event && (wr_addr == `OFS_DEEP_SLEEP_ENTRY) &&
                   wr_data[`BIT_SLEEP_REQ]); // [RULE12]
    burst_exit  = wr_event && (wr_addr == `OFS_BURST_WRITE_LEAVE); // [RULE1]
  end

  // Read data selection; unmapped words do not drive the bus
  always_comb
  begin
    rd_word = `WORD_ZERO;
    rd_hit  = 1'b1;
    case (pins.addr)
      `OFS_BURST_WRITE_CTRL:
        rd_word[`BIT_BURST_EN] = state_reg.burst_wr_en; // [RULE20]
      `OFS_BURST_READ_CTRL:
        rd_word[`BIT_BURST_EN] = state_reg.burst_rd_en; // [RULE20]
      `OFS_LOADER_COPY_STATUS:
        rd_word[`BIT_LOADER_RUN] = state_reg.loader_run; // [RULE4]
      `OFS_BOOT_WINDOW_CONTROL:
      begin
        rd_word[`BIT_WIN_OK]                  = boot_window_ready; // [RULE8]
        rd_word[`BIT_WIN_ALLOW]               = state_reg.win_allow;
        rd_word[`BIT_SHUT_HI:`BIT_SHUT_LO]    = state_reg.shut_sel;
      end
      `OFS_WARM_RESET_CONFIG:
      begin
        rd_word[`BIT_WARM_LEVEL] = state_reg.warm_level;
        rd_word[`BIT_KEEP_BURST] = state_reg.keep_burst;
      end
      `OFS_WAKE_SOURCE_CONFIG:
        rd_word[`BIT_WAKE_SEL] = state_reg.wake_sel;
      `OFS_REQUEST_LINE_CONTROL:
      begin
        rd_word[`BIT_REQ_EN]                     = state_reg.req_cfg.enable;
        rd_word[`BIT_REQ_LEVEL]                  = state_reg.req_cfg.level_low;
        rd_word[`BIT_REQ_STYLE]                  = state_reg.req_cfg.pulse_style;
        rd_word[`BIT_STROBE_HI:`BIT_STROBE_LO]   = state_reg.req_cfg.strobe_len;
      end
      `OFS_EARLY_DROP:
        rd_word[`BIT_DROP_HI:0] = state_reg.req_cfg.drop_count;
      `OFS_DEEP_SLEEP_ENTRY:
        rd_word = `WORD_ZERO; // Request bit is write-only
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Next state of the bank
  always_comb
  begin
    state_next                = state_reg;
    state_next.prev           = pins;
    state_next.warm_prev      = warm_active;
    state_next.sleep_pin_prev = pins.sleep_pin;
    state_next.warm_seen      = warm_edge;
    state_next.rdata          = rd_word;
    state_next.rdata_oe       = rd_active && rd_hit;

    // Copy status falls once the loader is in the boot block
    if (loader_copy_done)
      state_next.loader_run = 1'b0; // [RULE4]

    // Allow drops by itself if the window stops being writable
    if (!boot_window_ready)
      state_next.win_allow = 1'b0; // [RULE7]

    if (wr_event)
    begin
      case (wr_addr)
        `OFS_BURST_WRITE_CTRL:
          state_next.burst_wr_en = wr_data[`BIT_BURST_EN]; // [RULE20]
        `OFS_BURST_READ_CTRL:
          state_next.burst_rd_en = wr_data[`BIT_BURST_EN]; // [RULE20]
        `OFS_BOOT_WINDOW_CONTROL:
        begin
          state_next.shut_sel  = wr_data[`BIT_SHUT_HI:`BIT_SHUT_LO]; // [RULE6]
          // A set is only taken while the window reports ready
          state_next.win_allow = wr_data[`BIT_WIN_ALLOW] && boot_window_ready; // [RULE7]
        end
        `OFS_WARM_RESET_CONFIG:
        begin
          state_next.warm_level = wr_data[`BIT_WARM_LEVEL]; // [RULE10]
          state_next.keep_burst = wr_data[`BIT_KEEP_BURST]; // [RULE9]
        end
        `OFS_WAKE_SOURCE_CONFIG:
          state_next.wake_sel = wr_data[`BIT_WAKE_SEL]; // [RULE11]
        `OFS_REQUEST_LINE_CONTROL:
        begin
          state_next.req_cfg.enable      = wr_data[`BIT_REQ_EN]; // [RULE16]
          state_next.req_cfg.level_low   = wr_data[`BIT_REQ_LEVEL]; // [RULE18]
          state_next.req_cfg.pulse_style = wr_data[`BIT_REQ_STYLE]; // [RULE17]
          state_next.req_cfg.strobe_len  = wr_data[`BIT_STROBE_HI:`BIT_STROBE_LO]; // [RULE13]
        end
        `OFS_EARLY_DROP:
          state_next.req_cfg.drop_count = wr_data[`BIT_DROP_HI:0]; // [RULE19]
        default:
          state_next.sleeping = state_reg.sleeping;
      endcase
    end

    // Warm reset overrides a same-cycle burst register write
    if (warm_edge && !state_reg.keep_burst) // [RULE9]
    begin
      state_next.burst_wr_en = 1'b0;
      state_next.burst_rd_en = 1'b0;
    end

    // Burst write mode: start event wins over the leave write
    if (burst_write_begin)
      state_next.burst_wr_mode = 1'b1;
    else if (burst_exit)
      state_next.burst_wr_mode = 1'b0; // [RULE1]

    // Deep sleep: entry wins over a simultaneous wake
    if (sleep_enter)
      state_next.sleeping = 1'b1; // [RULE12]
    else if (state_reg.sleeping && wake_event)
      state_next.sleeping = 1'b0; // [RULE11]
  end

  // Bank registers; strobe history resets to idle-high
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg                     <= '0;
      state_reg.loader_run          <= `RST_LOADER_RUN; // [RULE4]
      state_reg.req_cfg.level_low   <= `RST_REQ_LEVEL; // [RULE18]
      state_reg.req_cfg.strobe_len  <= `RST_STROBE_LEN; // [RULE13]
      state_reg.req_cfg.drop_count  <= `RST_DROP_COUNT; // [RULE19]
      state_reg.prev                <= '1;
      state_reg.warm_prev           <= 1'b1;
      state_reg.sleep_pin_prev      <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // ----------
  // Transfer request generator
  // ----------
  request_strobe u_request_strobe
  (
    .mclk               (mclk),
    .resetn             (resetn),
    .cfg                (state_reg.req_cfg),
    .data_ready         (xfer_data_ready),
    .clocks_left        (xfer_clocks_left),
    .transfer_request_n (transfer_request_n)
  );

  // ----------
  // Outputs, all straight from flip-flops (bank state, ok_reg for the ok flag, the request generator's line flip-flop for the request)
  // ----------
  // The ok flag is latched from the core's ready level
  logic ok_reg;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ok_reg <= 1'b0;
    else
      ok_reg <= boot_window_ready; // [RULE8]
  end

  assign data_out                = state_reg.rdata;
  assign data_oe                 = state_reg.rdata_oe;
  assign boot_window_write_allow = state_reg.win_allow;
  assign boot_window_write_ok    = ok_reg;
  assign lower_ram_off           = state_reg.shut_sel[0]; // [RULE6]
  assign upper_ram_off           = state_reg.shut_sel[1]; // [RULE6]
  assign burst_read_enable       = state_reg.burst_rd_en;
  assign burst_write_enable      = state_reg.burst_wr_en;
  assign burst_write_active      = state_reg.burst_wr_mode;
  assign deep_sleep_active       = state_reg.sleeping;
  assign warm_reset_seen         = state_reg.warm_seen;

endmodule

// file: dma_request_sink.sv
// Host-side model measuring each transfer request
`timescale 1ns/1ps
module dma_request_sink
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       transfer_request_n,
  input  wire logic       active_low,
  output logic            active,
  output logic [7:0]      last_width,
  output logic [7:0]      req_count
);
  logic [7:0] run_reg;

  // Decoded with the controller's polarity
  assign active = transfer_request_n ^ active_low;

  // Request width in core clocks, counted at its end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      run_reg    <= 8'h00;
      last_width <= 8'h00;
      req_count  <= 8'h00;
    end
    else if (active)
      run_reg <= run_reg + 8'h01;
    else if (run_reg != 8'h00)
    begin
      last_width <= run_reg;
      req_count  <= req_count + 8'h01;
      run_reg    <= 8'h00;
    end
  end
endmodule

// file: boot_power_dma_control_regs_assertions.sv
// Port-level checks of the host control register block
`timescale 1ns/1ps
`include "ctrl_regs_consts.svh"
module boot_power_dma_control_regs_checker
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [16:0] addr,
  input wire logic        deep_sleep_pin,
  input wire logic        boot_window_ready,
  input wire logic        burst_write_begin,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        boot_window_write_allow,
  input wire logic        boot_window_write_ok,
  input wire logic        burst_write_active,
  input wire logic        deep_sleep_active,
  input wire logic        warm_reset_seen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------
  // Properties
  // ----------
  property p_leave_write;
    $rose(we_n) && !ce_n && addr == `OFS_BURST_WRITE_LEAVE && !burst_write_begin
      |-> ##[2:5] !burst_write_active;
  endproperty
  a_leave_write: assert property (p_leave_write) else $error("burst write mode kept");

  property p_read_gate;
    data_oe |-> !$past(addr[0], 3) && !$past(ce_n, 3) && !$past(oe_n, 3);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read driven without access");

  property p_copy_rsvd;
    data_oe && $past(addr, 3) == `OFS_LOADER_COPY_STATUS |-> data_out[15:1] == 15'h0000;
  endproperty
  a_copy_rsvd: assert property (p_copy_rsvd) else $error("copy status spare bits set");

  property p_sleep_reads0;
    data_oe && $past(addr, 3) == `OFS_DEEP_SLEEP_ENTRY |-> data_out == `WORD_ZERO;
  endproperty
  a_sleep_reads0: assert property (p_sleep_reads0) else $error("sleep entry read not 0");

  property p_pin_sleep;
    $rose(deep_sleep_pin) && ce_n |-> ##[2:5] deep_sleep_active;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("sleep pin ignored");

  // No wake while chip select stays high
  property p_wake_hold;
    deep_sleep_active && ce_n && $past(ce_n) |=> deep_sleep_active;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("woke without access");

  property p_ok_follow;
    $past(resetn) |-> boot_window_write_ok == $past(boot_window_ready);
  endproperty
  a_ok_follow: assert property (p_ok_follow) else $error("write ok flag wrong");

  property p_allow_guard;
    $rose(boot_window_write_allow) |-> $past(boot_window_ready);
  endproperty
  a_allow_guard: assert property (p_allow_guard) else $error("allow set before ok");

  property p_seen_pulse;
    warm_reset_seen |=> !warm_reset_seen;
  endproperty
  a_seen_pulse: assert property (p_seen_pulse) else $error("warm reset pulse too long");
endmodule

bind boot_power_dma_control_regs boot_power_dma_control_regs_checker i_chk
(
  .mclk(mclk), .resetn(resetn), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
  .deep_sleep_pin(deep_sleep_pin), .boot_window_ready(boot_window_ready),
  .burst_write_begin(burst_write_begin), .data_out(data_out), .data_oe(data_oe),
  .boot_window_write_allow(boot_window_write_allow),
  .boot_window_write_ok(boot_window_write_ok), .burst_write_active(burst_write_active),
  .deep_sleep_active(deep_sleep_active), .warm_reset_seen(warm_reset_seen)
);

// file: boot_power_dma_control_regs_bench.sv
// Self-checking bench of the host control register block
`timescale 1ns/1ps
module boot_power_dma_control_regs_bench;
  logic        mclk, resetn, ce_n, oe_n, we_n, warm_pin, sleep_pin, copy_done;
  logic        ready, bw_begin, xready, pol, req_active;
  logic [16:0] addr;
  logic [15:0] data_in, data_out, left;
  logic        data_oe, req_n, allow, ok, lo_off, hi_off, brd, bwr, bwa, sleep, seen;
  logic [7:0]  width, req_cnt, c0, w0;
  int          error_cnt, tests_run, cyc, warm_cnt;
  logic [15:0] dcfg [5] = '{16'h0015, 16'h01F5, 16'h0017, 16'h0005, 16'h0044};
  logic [7:0]  dinc [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0]  dwid [5] = '{8'h01, 8'h1F, 8'h01, 8'h00, 8'h00};
  wire  [15:0] flags = {7'h00, req_active, allow, ok, lo_off, hi_off, brd, bwr, bwa, sleep};

  boot_power_dma_control_regs i_dut
  (
    .mclk(mclk), .resetn(resetn), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .data_in(data_in), .warm_reset_pin(warm_pin), .deep_sleep_pin(sleep_pin),
    .loader_copy_done(copy_done), .boot_window_ready(ready), .burst_write_begin(bw_begin),
    .xfer_data_ready(xready), .xfer_clocks_left(left), .data_out(data_out), .data_oe(data_oe),
    .transfer_request_n(req_n), .boot_window_write_allow(allow), .boot_window_write_ok(ok),
    .lower_ram_off(lo_off), .upper_ram_off(hi_off), .burst_read_enable(brd),
    .burst_write_enable(bwr), .burst_write_active(bwa), .deep_sleep_active(sleep),
    .warm_reset_seen(seen)
  );

  dma_request_sink i_sink
  (
    .mclk(mclk), .resetn(resetn), .transfer_request_n(req_n), .active_low(pol),
    .active(req_active), .last_width(width), .req_count(req_cnt)
  );

  // ----------
  // Clock, hang guard, pulse counter
  // ----------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // About 750 cycles needed; ceiling leaves wide margin
  always @(posedge mclk)
  begin
    cyc++;
    if (seen === 1'b1)
      warm_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // ----------
  // Tasks
  // ----------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flags sampled mid-cycle, away from their update edges
  task automatic cflag(input logic [15:0] exp);
    @(negedge mclk);
    chk(flags, exp);
    @(posedge mclk);
  endtask

  // Strobes held past the synchroniser before release
  task automatic wr(input logic [16:0] a, input logic [15:0] d);
    ce_n    <= 1'b0;
    we_n    <= 1'b0;
    addr    <= a;
    data_in <= d;
    step(4);
    we_n <= 1'b1;
    step(5);
    ce_n <= 1'b1;
    step(3);
  endtask

  task automatic rd(input logic [16:0] a, input logic oe_exp, input logic [15:0] exp);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    step(5);
    @(negedge mclk);
    chk(16'(data_oe), 16'(oe_exp));
    if (oe_exp)
      chk(data_out, exp);
    @(posedge mclk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    step(4);
  endtask

  task automatic final_report();
    $display("Counts: errors=%0d comparisons=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    {resetn, ce_n, oe_n, we_n, warm_pin, pol} = 6'h1F;
    {sleep_pin, copy_done, ready, bw_begin, xready, addr, data_in} = '0;
    left = 16'h0064;
    step(20);
    resetn <= 1'b1;
    step(3);
    rd(17'h09406, 1'b1, 16'h0001);
    copy_done <= 1'b1;
    step(1);
    copy_done <= 1'b0;
    rd(17'h09406, 1'b1, 16'h0000);
    rd(17'h0940E, 1'b1, 16'h0042);
    rd(17'h09418, 1'b1, 16'h0004);
    wr(17'h0940F, 16'h0055);
    rd(17'h0940E, 1'b1, 16'h0042);
    rd(17'h0940F, 1'b0, 16'h0000);
    wr(17'h09408, 16'h0002);
    rd(17'h09408, 1'b1, 16'h0000);
    ready <= 1'b1;
    step(2);
    rd(17'h09408, 1'b1, 16'h0001);
    for (int s = 0; s < 4; s++)
    begin
      wr(17'h09408, {10'h000, s[1:0], 4'h2});
      cflag({8'h00, 2'b11, s[0], s[1], 4'h0});
      rd(17'h09408, 1'b1, {10'h000, s[1:0], 4'h3});
    end
    wr(17'h09408, 16'h0000);
    wr(17'h09402, 16'h0002);
    wr(17'h09424, 16'h0002);
    cflag(16'h004C);
    warm_pin <= 1'b0;
    step(8);
    warm_pin <= 1'b1;
    cflag(16'h0040);
    warm_pin <= 1'b0;
    wr(17'h0940A, 16'h0003);
    wr(17'h09402, 16'h0002);
    wr(17'h09424, 16'h0002);
    warm_pin <= 1'b1;
    step(8);
    warm_pin <= 1'b0;
    cflag(16'h004C);
    chk(16'(warm_cnt), 16'h0003);
    bw_begin <= 1'b1;
    step(1);
    bw_begin <= 1'b0;
    cflag(16'h004E);
    wr(17'h09404, 16'hA5A5);
    cflag(16'h004C);
    wr(17'h09416, 16'h0001);
    cflag(16'h004D);
    rd(17'h09416, 1'b1, 16'h0000);
    cflag(16'h004C);
    wr(17'h0940C, 16'h0100);
    wr(17'h09416, 16'h0001);
    ce_n <= 1'b0;
    step(6);
    cflag(16'h004D);
    ce_n <= 1'b1;
    step(3);
    rd(17'h0940C, 1'b1, 16'h0100);
    sleep_pin <= 1'b1;
    step(6);
    cflag(16'h004D);
    sleep_pin <= 1'b0;
    rd(17'h0940C, 1'b1, 16'h0100);
    cflag(16'h004C);
    for (int i = 0; i < 5; i++)
    begin
      wr(17'h0940E, dcfg[i]);
      pol <= dcfg[i][1];
      step(2);
      c0 = req_cnt;
      w0 = width;
      xready <= 1'b1;
      step(40);
      xready <= 1'b0;
      step(3);
      chk({8'h00, req_cnt - c0}, {8'h00, dinc[i]});
      chk({8'h00, width}, {8'h00, (dinc[i] != 8'h00) ? dwid[i] : w0});
    end
    wr(17'h09418, 16'h0005);
    wr(17'h0940E, 16'h0041);
    pol <= 1'b0;
    step(2);
    xready <= 1'b1;
    step(8);
    cflag(16'h014C);
    left <= 16'h0005;
    step(3);
    cflag(16'h004C);
    xready <= 1'b0;
    step(2);
    final_report();
  end
endmodule
